//--- rtl/smsc_pkg.sv
/*
 * Shared constants, types and decode helpers of the serial controller.
 * Assumes a 12-bit AXI4-Lite byte address and 8-bit registers.
 */
package smsc_pkg;

  // ------------------------------------------------------------------
  // Register map.
  // ------------------------------------------------------------------
  localparam int              ADDR_W    = 12;
  localparam logic [7:0]      IDX_CTRL  = 8'hF3;
  localparam logic [7:0]      IDX_STAT  = 8'hF4;
  localparam logic [7:0]      IDX_DATA  = 8'hF5;
  localparam logic [11:0]     ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0]     ADDR_STAT = {2'b00, IDX_STAT, 2'b00};
  localparam logic [11:0]     ADDR_DATA = {2'b00, IDX_DATA, 2'b00};
  localparam logic [7:0]      CTRL_RESET = 8'h00;
  localparam logic [7:0]      DATA_RESET = 8'h00;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------------
  localparam int CTRL_SELECT_OUTPUT_ENABLE = 7;
  localparam int CTRL_EN   = 6;
  localparam int CTRL_LSB  = 5;
  localparam int CTRL_MASTER_ROLE = 4;
  localparam int CTRL_CLOCK_IDLE_LEVEL = 3;
  localparam int CTRL_SAMPLE_EDGE_SELECT = 2;
  localparam int CTRL_RHI  = 1;
  localparam int CTRL_RLO  = 0;
  localparam int STAT_DONE = 7;
  localparam int STAT_WCOL = 6;
  localparam int STAT_OVF  = 5;
  localparam int STAT_ROLE_FAULT_FLAG = 4;
  localparam int STAT_DMF  = 3;

  // ------------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------------
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [3:0] LAST_EDGE   = 4'hF;
  localparam int         BYTE_BITS   = 8;

  typedef enum logic {SMSC_IDLE, SMSC_XFER} smsc_state_e;

  // Reports whether a byte address hits one of the three registers.
  function automatic logic smscHit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    return (w == ADDR_CTRL) || (w == ADDR_STAT) || (w == ADDR_DATA);
  endfunction

endpackage

//--- rtl/smsc_rate_div.sv
/*
 * Half-period tick generator for the master shift clock.
 * Assumes run is held high for the whole of a master transfer.
 */
`timescale 1ns/100ps
module smsc_rate_div
  import smsc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [1:0] rateSel,
  output logic            tick
);

  typedef struct packed {
    logic [6:0] cnt;
  } smsc_div_s;

  smsc_div_s stateReg;
  smsc_div_s stateNext;
  logic [6:0] halfCnt;

  // Maps the rate code onto half of the divide ratio.
  function automatic logic [6:0] halfOf(input logic [1:0] code);
    case (code)
      2'b00:   return HALF_DIV16;
      2'b01:   return HALF_DIV32;
      2'b10:   return HALF_DIV64;
      default: return HALF_DIV128;
    endcase
  endfunction

  assign halfCnt = halfOf(rateSel);
  assign tick    = run && (stateReg.cnt == halfCnt - 7'h01);

  always_comb begin
    stateNext = stateReg;
    if (!run || tick) begin
      stateNext.cnt = 7'h00;
    end else begin
      stateNext.cnt = stateReg.cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

endmodule // smsc_rate_div

//--- rtl/smsc_axil_slave.sv
/*
 * AXI4-Lite slave front end: one write and one read at a time.
 * Assumes the parent decodes wrEn into register writes and
 * supplies rdData combinationally for rdAddr.
 */
`timescale 1ns/100ps
module smsc_axil_slave
  import smsc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wrEn,
  output logic [ADDR_W-1:0]      wrAddr,
  output logic [7:0]             wrData,
  output logic [ADDR_W-1:0]      rdAddr,
  input  wire logic [7:0]        rdData
);

  typedef struct packed {
    logic [ADDR_W-1:0] awAddr;
    logic              awHave;
    logic [7:0]        wData;
    logic              wLane0;
    logic              wHave;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [1:0]        rResp;
    logic [31:0]       rData;
  } smsc_axi_s;

  smsc_axi_s stateReg;
  smsc_axi_s stateNext;

  assign s_axi_awready = !stateReg.awHave && !stateReg.bValid;
  assign s_axi_wready  = !stateReg.wHave && !stateReg.bValid;
  assign s_axi_arready = !stateReg.rValid;
  assign s_axi_bvalid  = stateReg.bValid;
  assign s_axi_bresp   = stateReg.bResp;
  assign s_axi_rvalid  = stateReg.rValid;
  assign s_axi_rresp   = stateReg.rResp;
  assign s_axi_rdata   = stateReg.rData;
  assign wrAddr        = stateReg.awAddr;
  assign wrData        = stateReg.wData;
  assign rdAddr        = s_axi_araddr;
  assign wrEn = stateReg.awHave && stateReg.wHave && stateReg.wLane0 &&
                smscHit(stateReg.awAddr);

  always_comb begin
    stateNext = stateReg;
    if (s_axi_awvalid && s_axi_awready) begin
      stateNext.awAddr = s_axi_awaddr;
      stateNext.awHave = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      stateNext.wData  = s_axi_wdata[7:0];
      stateNext.wLane0 = s_axi_wstrb[0];
      stateNext.wHave  = 1'b1;
    end
    if (stateReg.awHave && stateReg.wHave) begin
      stateNext.awHave = 1'b0;
      stateNext.wHave  = 1'b0;
      stateNext.bValid = 1'b1;
      stateNext.bResp  = smscHit(stateReg.awAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (stateReg.bValid && s_axi_bready) begin
      stateNext.bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      stateNext.rValid = 1'b1;
      stateNext.rResp  = smscHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      stateNext.rData  = {24'h00_0000, rdData};
    end else if (stateReg.rValid && s_axi_rready) begin
      stateNext.rValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

endmodule // smsc_axil_slave

//--- rtl/smsc_core.sv
/*
 * Serial peripheral controller, master or slave, one byte a transfer,
 * with its register file behind an AXI4-Lite slave.
 * Assumes all pin inputs are synchronous to ref_clk and that the pad
 * logic resolves each pin from its output enable.
 */
// Function
// - Master bit rate at most clock/16, slave at most clock/4.
// - Transmit buffer is the shifter; receive has a separate read buffer.
// - New transmit data is refused while a transfer runs.
// - Each finished byte moves into the read buffer unless done is still set; then the overflow flag is set instead.
// - Master drives MOSI, samples MISO; slave drives MISO, samples MOSI.
// - Shift clock is output as master, input as slave.
// - Master makes exactly eight shift clock cycles per byte.
// - Slave works only while select is low; one slave selected.
// - Master select pin: general I/O, fault input or automatic output.
// - Transfer swaps master and slave shift register contents.
// - Bit order MSB first by default, LSB first on request.
// - Select output drives low per transfer when master and fault-off; the code also requires control bits 6 and 7 set.
// - Control bit 6 enables the interface; the shift clock output enable follows bit 4 alone.
// - Control bit 4 picks master (1) or slave (0).
// - Control bit 3 gives the idle shift clock level.
// - Control bit 2 picks first or second edge for sampling.
// - Done flag set by hardware, cleared by software, blocks data writes.
// - Master data write starts a transfer.
// - Master with fault detect on sets fault flag on low select.
// - Slave select rising mid-byte aborts, fills rest with ones.
`timescale 1ns/100ps
module smsc_core
  import smsc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sclkIn,
  output logic                   sclkOut,
  output logic                   sclkOe,
  input  wire logic              mosiIn,
  output logic                   mosiOut,
  output logic                   mosiOe,
  input  wire logic              misoIn,
  output logic                   misoOut,
  output logic                   misoOe,
  input  wire logic              selectIn,
  output logic                   selectOut,
  output logic                   selectOe
);

  // ------------------------------------------------------------------
  // State.
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        done;
    logic        wcol;
    logic        ovf;
    logic        role_fault_flag;
    logic        dmf;
    logic [7:0]  shreg;
    logic [7:0]  rdBuf;
    smsc_state_e st;
    logic [3:0]  edgeCnt;
    logic [3:0]  sampCnt;
    logic        outBit;
    logic        sclkLvl;
    logic        selLvl;
    logic        sclkPrev;
  } smsc_core_s;

  smsc_core_s stateReg;
  smsc_core_s stateNext;

  logic              wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0]        wrData;
  logic [ADDR_W-1:0] rdAddr;
  logic [7:0]        rdData;
  logic              tick;
  logic              en;
  logic              master_role;
  logic              lsb;
  logic              sample_edge_select;
  logic              xfer;
  logic              dataWr;
  logic              ctrlWr;
  logic              statWr;
  logic              edgeEv;
  logic              sampleEv;
  logic              lastEdge;
  logic              slvAbort;
  logic              faultHit;
  logic              mstStart;
  logic              inBit;
  logic [7:0]        shSample;
  logic [7:0]        statRd;

  assign en    = stateReg.ctrl[CTRL_EN];
  assign master_role  = stateReg.ctrl[CTRL_MASTER_ROLE];
  assign lsb   = stateReg.ctrl[CTRL_LSB];
  assign sample_edge_select  = stateReg.ctrl[CTRL_SAMPLE_EDGE_SELECT];
  assign xfer  = (stateReg.st == SMSC_XFER);

  // ------------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------------
  // Shifts one received bit into the byte in the chosen order.
  function automatic logic [7:0] shiftIn(input logic [7:0] sh,
                                         input logic       b,
                                         input logic       lsbF);
    return lsbF ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // Picks the bit that leaves the shifter next.
  function automatic logic firstBit(input logic [7:0] sh,
                                    input logic       lsbF);
    return lsbF ? sh[0] : sh[7];
  endfunction

  // Completes an aborted byte by shifting in ones for the missing bits.
  function automatic logic [7:0] fillOnes(input logic [7:0] sh,
                                          input logic [3:0] got,
                                          input logic       lsbF);
    logic [7:0] r;
    r = sh;
    for (int i = 0; i < BYTE_BITS; i++) begin
      if (i >= int'(got)) begin
        r = shiftIn(r, 1'b1, lsbF);
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Bus front end and rate divider.
  // ------------------------------------------------------------------
  smsc_axil_slave u_bus (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrEn          (wrEn),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .rdAddr        (rdAddr),
    .rdData        (rdData)
  );

  smsc_rate_div u_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .run     (xfer && master_role && en),
    .rateSel (stateReg.ctrl[CTRL_RHI:CTRL_RLO]),
    .tick    (tick)
  );

  // ------------------------------------------------------------------
  // Decode and event terms.
  // ------------------------------------------------------------------
  assign ctrlWr = wrEn && (wrAddr[ADDR_W-1:2] == ADDR_CTRL[ADDR_W-1:2]);
  assign statWr = wrEn && (wrAddr[ADDR_W-1:2] == ADDR_STAT[ADDR_W-1:2]);
  assign dataWr = wrEn && (wrAddr[ADDR_W-1:2] == ADDR_DATA[ADDR_W-1:2]);

  assign statRd = {stateReg.done, stateReg.wcol, stateReg.ovf,
                   stateReg.role_fault_flag, stateReg.dmf, 3'b000};
  always_comb begin
    if (rdAddr[ADDR_W-1:2] == ADDR_CTRL[ADDR_W-1:2]) begin
      rdData = stateReg.ctrl;
    end else if (rdAddr[ADDR_W-1:2] == ADDR_STAT[ADDR_W-1:2]) begin
      rdData = statRd;
    end else if (rdAddr[ADDR_W-1:2] == ADDR_DATA[ADDR_W-1:2]) begin
      rdData = stateReg.rdBuf;
    end else begin
      rdData = 8'h00;
    end
  end

  assign faultHit = en && master_role && !stateReg.dmf && !selectIn;
  assign mstStart = dataWr && en && master_role && !xfer && !stateReg.done &&
                    !faultHit;
  assign inBit    = master_role ? misoIn : mosiIn;
  assign edgeEv   = xfer && (master_role ? tick
                             : (sclkIn != stateReg.sclkPrev));
  assign sampleEv = edgeEv && (stateReg.edgeCnt[0] == sample_edge_select);
  assign lastEdge = edgeEv && (stateReg.edgeCnt == LAST_EDGE);
  assign slvAbort = xfer && !master_role && selectIn;
  assign shSample = sampleEv ? shiftIn(stateReg.shreg, inBit, lsb)
                             : stateReg.shreg;

  // ------------------------------------------------------------------
  // Next state.
  // ------------------------------------------------------------------
  always_comb begin
    stateNext          = stateReg;
    stateNext.sclkPrev = sclkIn;
    if (ctrlWr) begin
      stateNext.ctrl = wrData;
    end
    if (statWr) begin
      stateNext.done = stateReg.done & wrData[STAT_DONE];
      stateNext.wcol = stateReg.wcol & wrData[STAT_WCOL];
      stateNext.ovf  = stateReg.ovf  & wrData[STAT_OVF];
      stateNext.role_fault_flag = stateReg.role_fault_flag & wrData[STAT_ROLE_FAULT_FLAG];
      stateNext.dmf  = wrData[STAT_DMF];
    end
    if (faultHit) begin
      stateNext.role_fault_flag = 1'b1;
    end
    if (dataWr && en && xfer) begin
      stateNext.wcol = 1'b1;
    end
    if (!en) begin
      stateNext.st      = SMSC_IDLE;
      stateNext.sclkLvl = stateReg.ctrl[CTRL_CLOCK_IDLE_LEVEL];
      stateNext.outBit  = firstBit(stateReg.shreg, lsb);
    end else if (!xfer) begin
      stateNext.sclkLvl = stateReg.ctrl[CTRL_CLOCK_IDLE_LEVEL];
      stateNext.edgeCnt = 4'h0;
      stateNext.sampCnt = 4'h0;
      stateNext.outBit  = firstBit(stateReg.shreg, lsb);
      if (mstStart) begin
        stateNext.shreg  = wrData;
        stateNext.outBit = firstBit(wrData, lsb);
        stateNext.st     = SMSC_XFER;
      end else if (dataWr && !stateReg.done) begin
        stateNext.shreg  = wrData;
        stateNext.outBit = firstBit(wrData, lsb);
      end
      if (!master_role && !selectIn) begin
        stateNext.st = SMSC_XFER;
      end
    end else if (slvAbort) begin
      stateNext.shreg = fillOnes(stateReg.shreg, stateReg.sampCnt,
                                 lsb);
      stateNext.st    = SMSC_IDLE;
    end else if (edgeEv) begin
      stateNext.edgeCnt = stateReg.edgeCnt + 4'h1;
      stateNext.shreg   = shSample;
      if (master_role) begin
        stateNext.sclkLvl = !stateReg.sclkLvl;
      end
      if (sampleEv) begin
        stateNext.sampCnt = stateReg.sampCnt + 4'h1;
      end else begin
        stateNext.outBit = firstBit(stateReg.shreg, lsb);
      end
      if (lastEdge) begin
        stateNext.st   = SMSC_IDLE;
        stateNext.done = 1'b1;
        if (stateReg.done) begin
          stateNext.ovf = 1'b1;
        end else begin
          stateNext.rdBuf = shSample;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg        <= '0;
      stateReg.ctrl   <= CTRL_RESET;
      stateReg.rdBuf  <= DATA_RESET;
      stateReg.selLvl <= 1'b1;
    end else begin
      stateReg        <= stateNext;
      stateReg.selLvl <= (stateNext.st != SMSC_XFER);
    end
  end

  // ------------------------------------------------------------------
  // Pins.
  // ------------------------------------------------------------------
  assign sclkOut   = stateReg.sclkLvl;
  assign sclkOe    = master_role;
  assign mosiOut   = stateReg.outBit;
  assign mosiOe    = en && master_role;
  assign misoOut   = stateReg.outBit;
  assign misoOe    = en && !master_role && !selectIn;
  assign selectOut = stateReg.selLvl;
  assign selectOe  = en && master_role && stateReg.dmf &&
                     stateReg.ctrl[CTRL_SELECT_OUTPUT_ENABLE];

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_done_on_end: assert property (
    lastEdge && en && !slvAbort |=> stateReg.done && !xfer)
    else $error("done flag not set after last edge");
  a_busy_write: assert property (
    dataWr && en && xfer |=> stateReg.wcol)
    else $error("write during transfer not flagged");
  a_done_blocks: assert property (
    dataWr && stateReg.done && !xfer && en |=> $stable(stateReg.shreg))
    else $error("data write accepted while done set");
  a_master_start: assert property (
    mstStart |=> xfer && stateReg.shreg == $past(wrData)
             && !selectOut)
    else $error("master write did not start transfer");
  a_clock_idle: assert property (
    !xfer && $past(!xfer) && $stable(stateReg.ctrl) |-> sclkOut
      == stateReg.ctrl[CTRL_CLOCK_IDLE_LEVEL])
    else $error("shift clock not at idle level");
  a_fault_flag: assert property (
    faultHit |=> stateReg.role_fault_flag)
    else $error("mode fault not flagged");
  a_select_auto: assert property (
    selectOe |-> selectOut == !xfer)
    else $error("select output wrong");
  a_abort_ones: assert property (
    slvAbort && stateReg.sampCnt == 4'h0 |=> stateReg.shreg == 8'hFF
      && !xfer)
    else $error("abort did not fill ones");
  a_pin_roles: assert property (
    en && master_role |-> mosiOe && !misoOe && sclkOe)
    else $error("master pin directions wrong");
  a_eight_cycles: assert property (
    lastEdge && master_role |-> stateReg.sampCnt == 4'h8 - {3'b000, sample_edge_select})
    else $error("byte ended with wrong bit count");

  c_master_byte: cover property (lastEdge && master_role);
  c_slave_byte: cover property (lastEdge && !master_role);
  c_slave_abort: cover property (slvAbort);
  c_mode_fault: cover property (faultHit);

endmodule // smsc_core

//--- bench/smsc_slave_model.sv
/*
 * Slave partner on the serial pins: mode 0, MSB first, one byte.
 * Assumes clock, data and select come from the controller's pins.
 */
`timescale 1ns/100ps
module smsc_slave_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       selN,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  logic [7:0] sh;
  logic       inBit;
  // A deselected slave lets its output wander from the last bit.
  assign miso = selN ? ~sh[7] : sh[7];
  always @(negedge selN) sh = txByte;
  always @(posedge sclk) inBit = mosi;
  always @(negedge sclk) begin
    sh = {sh[6:0], inBit};
    rxByte = sh;
  end
endmodule // smsc_slave_model

//--- bench/tb_top.sv
/*
 * Bench of the serial controller: AXI4-Lite tasks and master transfers.
 * Assumes the slave partner model on the pins and a 50 MHz ref_clk.
 */
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top import smsc_pkg::*; ;
  logic ref_clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe;
  logic selectOut, selectOe, misoM, ssExt = 1'b1;
  logic [7:0] slvTx = 8'h00, slvRx, got, tx, ctl;
  wire sclkIn = sclkOe ? sclkOut : 1'b0;
  wire mosiIn = mosiOe ? mosiOut : 1'b0;
  wire misoIn = misoOe ? misoOut : misoM;
  wire selectIn = selectOe ? selectOut : ssExt;
  int fails = 0, compares = 0, edges = 0, lowCnt = 0, i;
  always #10 ref_clk = ~ref_clk;
  always @(posedge sclkIn) edges++;
  always @(posedge ref_clk) if (!selectIn) lowCnt++;
  smsc_core i_smsc_core (.*);
  smsc_slave_model i_smsc_slave_model (.sclk(sclkIn), .mosi(mosiIn),
    .selN(selectIn), .txByte(slvTx), .miso(misoM), .rxByte(slvRx));
  // ------------------------------------------------------------------
  // Bus tasks and report.
  // ------------------------------------------------------------------
  task end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] d);
    int n;
    logic aH, wH, bH;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(negedge ref_clk);
      aH = s_axi_awvalid && s_axi_awready;
      wH = s_axi_wvalid && s_axi_wready;
      bH = s_axi_bvalid;
      @(posedge ref_clk);
      if (aH) s_axi_awvalid <= 1'b0;
      if (wH) s_axi_wvalid <= 1'b0;
      if (bH) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 99) begin fails++; end_of_test(); end
  endtask
  task automatic axr(input logic [11:0] a, output logic [7:0] d,
                     output logic [1:0] r);
    int n;
    logic aH, rH;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(negedge ref_clk);
      aH = s_axi_arvalid && s_axi_arready;
      rH = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (aH) s_axi_arvalid <= 1'b0;
      if (rH) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 99) begin fails++; end_of_test(); end
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    logic [7:0] o;
    for (int k = 0; k < 8; k++) o[k] = v[7-k];
    return o;
  endfunction
  // ------------------------------------------------------------------
  // Tests.
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    axr(ADDR_CTRL, got, rsp); `CHK(got, CTRL_RESET)
    axr(ADDR_DATA, got, rsp); `CHK(got, DATA_RESET)
    axr(12'h000, got, rsp); `CHK(rsp, RESP_SLVERR)
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      ctl = 8'hD0 | {6'h00, i[1:0]} | (i[0] ? 8'h20 : 8'h00);
      tx = 8'hA4 + 8'(i);
      axw(ADDR_STAT, 8'h08);
      axw(ADDR_CTRL, ctl);
      slvTx <= 8'h3C + 8'(i);
      edges = 0;
      lowCnt = 0;
      axw(ADDR_DATA, tx);
      for (int n = 0; n < 600; n++) begin
        axr(ADDR_STAT, got, rsp);
        if (got[7] === 1'b1) break;
      end
      `CHK(got[7], 1'b1)
      `CHK(edges, 8)
      `CHK(lowCnt, 8 * (16 << i))
      axr(ADDR_DATA, got, rsp);
      `CHK(got, i[0] ? rev(slvTx) : slvTx)
      `CHK(slvRx, i[0] ? rev(tx) : tx)
      axw(ADDR_DATA, 8'h55);
      repeat (40) @(posedge ref_clk);
      `CHK(edges, 8)
      $display("test transfer %0d done", i);
    end
    axw(ADDR_STAT, 8'h08);
    axw(ADDR_DATA, 8'h11);
    axw(ADDR_DATA, 8'h22);
    axr(ADDR_STAT, got, rsp); `CHK(got[6], 1'b1)
    repeat (1100) @(posedge ref_clk);
    axr(ADDR_DATA, got, rsp); `CHK(got, rev(8'h3F))
    `CHK(slvRx, rev(8'h11))
    axw(ADDR_STAT, 8'h00);
    ssExt <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ssExt <= 1'b1;
    axr(ADDR_STAT, got, rsp); `CHK(got[4], 1'b1)
    $display("test collision and fault done");
    axw(ADDR_CTRL, 8'h18);
    repeat (4) @(posedge ref_clk);
    `CHK(sclkOut, 1'b1)
    $display("test idle level done");
    end_of_test();
  end
endmodule // tb_top
